// [include/acr_pkg.sv]
// constants for the converter control and result block
// assumes an 8-bit special function register port with a page number for shared addresses
package acr_pkg;

    // register addresses and pages
    localparam logic [7:0] ADDR_CONFIG      = 8'hc3;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'hc3;
    localparam logic [7:0] ADDR_CONTROL     = 8'hc4;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hc6;
    localparam logic [3:0] PAGE_CONFIG_0    = 4'h0;
    localparam logic [3:0] PAGE_CONFIG_1    = 4'h1;

    // reset values
    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_CONFIG_0 = 8'h00;
    localparam logic [7:0] RESET_CONFIG_1 = 8'h00;
    localparam logic [11:0] RESET_RESULT  = 12'h000;

    // control register bits
    localparam int CTL_ON    = 7;
    localparam int CTL_WIN   = 6;
    localparam int CTL_CHS3  = 5;
    localparam int CTL_DONE  = 4;
    localparam int CTL_START = 3;

    // configuration 0 bits
    localparam int CF0_CKS_LSB = 5;
    localparam int CF0_RJ      = 4;
    localparam int CF0_AUX     = 3;
    localparam int CF0_SMP     = 2;

    // configuration 1 bits
    localparam int CF1_IGNORE = 7;
    localparam int CF1_WIEN   = 6;
    localparam int CF1_SIEN   = 5;

    // conversion clock select codes
    localparam logic [2:0] CKS_UART0_OVF  = 3'h6;
    localparam logic [2:0] CKS_TIMER2_OVF = 3'h7;

    // trigger mode codes
    localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
    localparam logic [1:0] TRIG_TIMER0   = 2'h1;
    localparam logic [1:0] TRIG_FREE     = 2'h2;
    localparam logic [1:0] TRIG_UART0    = 2'h3;

    // auxiliary channel codes
    localparam logic [3:0] AUX_REFERENCE = 4'h0;
    localparam logic [3:0] AUX_GROUND    = 4'h1;

    // result range
    localparam logic [11:0] RESULT_MAX = 12'hfff;

    // enable settle time that software must wait before starting
    localparam int CLK_PERIOD_NS      = 10;
    localparam int ENABLE_SETTLE_NS   = 5000;
    localparam int ENABLE_SETTLE_CYC  = (ENABLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } acr_state_t;

endpackage

// [logic/acr_adc_control.sv]
// converter control, flags, channel decode, clock select, trigger and result registers
// assumes the analog core and trigger sources run on clk and give one-cycle pulses
`timescale 1ns/1ns

// Contract
// - window match sets bit 6 flag
// - window enable gates window flag request
// - completion sets done flag bit 4
// - start bit 3 cleared by hardware at completion
// - no start while start or done high
// - aux and channel bits decode input mux
// - channel bit 3 at 5, rest 2..0
// - clock select divides or uses overflows
// - left justify puts result at top
// - right justify puts result at bottom
// - unused result bits read zero
// - result is 12-bit unsigned code
// - sampling done sets configuration 0 bit 2
// - sample enable gates sample flag request
// - ignore bit blocks done flag request
// - trigger mode picks start source
// - signed offset added to each result
// - window mode selects inside or outside
// - extended trigger bits must be zero here
module acr_adc_control (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [3:0]  sfrPage,
    input  wire logic        sfrWr,
    input  wire logic [7:0]  sfrWrData,
    output logic      [7:0]  sfrRdData,
    input  wire logic        timer0Overflow,
    input  wire logic        uart0BaudOverflow,
    input  wire logic        timer2Overflow,
    input  wire logic [1:0]  triggerModeHigh,
    input  wire logic        windowModeSelect,
    input  wire logic [11:0] windowHighBound,
    input  wire logic [11:0] windowLowBound,
    input  wire logic        coreSampleDone,
    input  wire logic        coreConvDone,
    input  wire logic [11:0] coreResult,
    output logic             converterOn,
    output logic             coreStart,
    output logic             coreClkEn,
    output logic             analogInputValid,
    output logic      [3:0]  analogInputSelect,
    output logic             selectInternalReference,
    output logic             selectAnalogGround,
    output logic             converterIrq
);

    acr_pkg::acr_state_t stateQ, stateD;
    logic        onQ, onD, winQ, winD, doneQ, doneD, startQ, startD;
    logic [3:0]  chsQ, chsD;
    logic [2:0]  cksQ, cksD;
    logic        rjQ, rjD, auxQ, auxD, smpQ, smpD;
    logic [1:0]  tmQ, tmD;
    logic        ignoreQ, ignoreD, wienQ, wienD, sienQ, sienD;
    logic [4:0]  ofsQ, ofsD;
    logic [11:0] resultQ, resultD;
    logic [4:0]  divCntQ, divCntD;
    logic        ovfTogQ, ovfTogD;
    logic        clkEnQ, clkEnD, coreStartQ, coreStartD, irqQ, irqD;
    logic [7:0]  rdDataQ, rdDataD;
    logic        inValidQ, inValidD, refQ, refD, gndQ, gndD;
    logic [3:0]  inSelQ, inSelD;

    logic        wrCtl, wrCfg0, wrCfg1, canStart, trigger, endConv, winMatch;
    logic [13:0] sum;
    logic [11:0] corrected;
    logic [7:0]  resHigh, resLow;
    logic [4:0]  divMask;

    assign wrCtl  = sfrWr && (sfrAddr == acr_pkg::ADDR_CONTROL);
    assign wrCfg0 = sfrWr && (sfrAddr == acr_pkg::ADDR_CONFIG) && (sfrPage == acr_pkg::PAGE_CONFIG_0);
    assign wrCfg1 = sfrWr && (sfrAddr == acr_pkg::ADDR_CONFIG) && (sfrPage == acr_pkg::PAGE_CONFIG_1);
    assign endConv = (stateQ == acr_pkg::ST_CONVERT) && coreConvDone && onQ;

    assign canStart = onQ && !startQ && !doneQ && (stateQ == acr_pkg::ST_IDLE);

    always_comb begin
        trigger = 1'b0;
        if (triggerModeHigh == 2'b00) begin
            unique case (tmQ)
                acr_pkg::TRIG_SOFTWARE: trigger = wrCtl && sfrWrData[acr_pkg::CTL_START];
                acr_pkg::TRIG_TIMER0:   trigger = timer0Overflow;
                acr_pkg::TRIG_FREE:     trigger = 1'b1;
                acr_pkg::TRIG_UART0:    trigger = uart0BaudOverflow;
            endcase
        end
    end

    assign sum = 14'({2'b00, coreResult}) + {{9{ofsQ[4]}}, ofsQ};

    always_comb begin
        if (sum[13]) begin
            corrected = 12'h000;
        end else if (sum[12]) begin
            corrected = acr_pkg::RESULT_MAX;
        end else begin
            corrected = sum[11:0];
        end
    end

    assign winMatch = windowModeSelect ^
                      ((corrected >= windowLowBound) && (corrected <= windowHighBound));

    // left justify, right justify, zero fill
    assign resHigh = rjQ ? {4'h0, resultQ[11:8]} : resultQ[11:4];
    assign resLow  = rjQ ? resultQ[7:0] : {resultQ[3:0], 4'h0};

    always_comb begin
        onD      = onQ;
        chsD     = chsQ;
        winD     = winQ;
        doneD    = doneQ;
        startD   = startQ;
        stateD   = stateQ;
        resultD  = resultQ;
        coreStartD = 1'b0;
        if (wrCtl) begin
            onD  = sfrWrData[acr_pkg::CTL_ON];
            chsD = {sfrWrData[acr_pkg::CTL_CHS3], sfrWrData[2:0]};
            if (!sfrWrData[acr_pkg::CTL_WIN]) begin
                winD = 1'b0;
            end
            if (!sfrWrData[acr_pkg::CTL_DONE]) begin
                doneD = 1'b0;
            end
        end
        unique case (stateQ)
            acr_pkg::ST_IDLE: begin
                if (canStart && trigger) begin
                    startD     = 1'b1;
                    coreStartD = 1'b1;
                    stateD     = acr_pkg::ST_CONVERT;
                end
            end
            acr_pkg::ST_CONVERT: begin
                if (!onQ) begin
                    startD = 1'b0;
                    stateD = acr_pkg::ST_IDLE;
                end else if (coreConvDone) begin
                    startD  = 1'b0;
                    doneD   = 1'b1;
                    resultD = corrected;
                    if (winMatch) begin
                        winD = 1'b1;
                    end
                    stateD = acr_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            onQ        <= acr_pkg::RESET_CONTROL[acr_pkg::CTL_ON];
            winQ       <= acr_pkg::RESET_CONTROL[acr_pkg::CTL_WIN];
            doneQ      <= acr_pkg::RESET_CONTROL[acr_pkg::CTL_DONE];
            startQ     <= acr_pkg::RESET_CONTROL[acr_pkg::CTL_START];
            chsQ       <= 4'h0;
            stateQ     <= acr_pkg::ST_IDLE;
            resultQ    <= acr_pkg::RESET_RESULT;
            coreStartQ <= 1'b0;
        end else begin
            onQ        <= onD;
            winQ       <= winD;
            doneQ      <= doneD;
            startQ     <= startD;
            chsQ       <= chsD;
            stateQ     <= stateD;
            resultQ    <= resultD;
            coreStartQ <= coreStartD;
        end
    end

    // configuration registers
    always_comb begin
        cksD    = cksQ;
        rjD     = rjQ;
        auxD    = auxQ;
        smpD    = smpQ;
        tmD     = tmQ;
        ignoreD = ignoreQ;
        wienD   = wienQ;
        sienD   = sienQ;
        ofsD    = ofsQ;
        if (wrCfg0) begin
            cksD = sfrWrData[acr_pkg::CF0_CKS_LSB +: 3];
            rjD  = sfrWrData[acr_pkg::CF0_RJ];
            auxD = sfrWrData[acr_pkg::CF0_AUX];
            tmD  = sfrWrData[1:0];
            if (!sfrWrData[acr_pkg::CF0_SMP]) begin
                smpD = 1'b0;
            end
        end
        if (coreSampleDone && onQ) begin
            smpD = 1'b1;
        end
        if (wrCfg1) begin
            ignoreD = sfrWrData[acr_pkg::CF1_IGNORE];
            wienD   = sfrWrData[acr_pkg::CF1_WIEN];
            sienD   = sfrWrData[acr_pkg::CF1_SIEN];
            ofsD    = sfrWrData[4:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cksQ    <= acr_pkg::RESET_CONFIG_0[acr_pkg::CF0_CKS_LSB +: 3];
            rjQ     <= acr_pkg::RESET_CONFIG_0[acr_pkg::CF0_RJ];
            auxQ    <= acr_pkg::RESET_CONFIG_0[acr_pkg::CF0_AUX];
            smpQ    <= acr_pkg::RESET_CONFIG_0[acr_pkg::CF0_SMP];
            tmQ     <= acr_pkg::RESET_CONFIG_0[1:0];
            ignoreQ <= acr_pkg::RESET_CONFIG_1[acr_pkg::CF1_IGNORE];
            wienQ   <= acr_pkg::RESET_CONFIG_1[acr_pkg::CF1_WIEN];
            sienQ   <= acr_pkg::RESET_CONFIG_1[acr_pkg::CF1_SIEN];
            ofsQ    <= acr_pkg::RESET_CONFIG_1[4:0];
        end else begin
            cksQ    <= cksD;
            rjQ     <= rjD;
            auxQ    <= auxD;
            smpQ    <= smpD;
            tmQ     <= tmD;
            ignoreQ <= ignoreD;
            wienQ   <= wienD;
            sienQ   <= sienD;
            ofsQ    <= ofsD;
        end
    end

    // conversion clock enable; divider idles while off to save toggling
    assign divMask = 5'((6'h01 << cksQ) - 6'h01);
    always_comb begin
        divCntD = onQ ? divCntQ + 5'h01 : 5'h00;
        ovfTogD = ovfTogQ;
        clkEnD  = 1'b0;
        if (onQ) begin
            if (cksQ == acr_pkg::CKS_UART0_OVF) begin
                ovfTogD = ovfTogQ ^ uart0BaudOverflow;
                clkEnD  = uart0BaudOverflow && ovfTogQ;
            end else if (cksQ == acr_pkg::CKS_TIMER2_OVF) begin
                ovfTogD = ovfTogQ ^ timer2Overflow;
                clkEnD  = timer2Overflow && ovfTogQ;
            end else begin
                clkEnD  = (divCntQ & divMask) == divMask;
            end
        end
    end

    // input mux decode, reserved codes select nothing
    always_comb begin
        inValidD = 1'b0;
        inSelD   = chsQ;
        refD     = 1'b0;
        gndD     = 1'b0;
        if (!auxQ) begin
            inValidD = 1'b1;
        end else begin
            refD = chsQ == acr_pkg::AUX_REFERENCE;
            gndD = chsQ == acr_pkg::AUX_GROUND;
        end
    end

    assign irqD = (doneQ && !ignoreQ) || (winQ && wienQ) || (smpQ && sienQ);

    always_comb begin
        rdDataD = 8'h00;
        if (sfrAddr == acr_pkg::ADDR_CONTROL) begin
            rdDataD = {onQ, winQ, chsQ[3], doneQ, startQ, chsQ[2:0]};
        end else if (sfrAddr == acr_pkg::ADDR_CONFIG) begin
            if (sfrPage == acr_pkg::PAGE_CONFIG_0) begin
                rdDataD = {cksQ, rjQ, auxQ, smpQ, tmQ};
            end else if (sfrPage == acr_pkg::PAGE_CONFIG_1) begin
                rdDataD = {ignoreQ, wienQ, sienQ, ofsQ};
            end else begin
                rdDataD = resLow;
            end
        end else if (sfrAddr == acr_pkg::ADDR_RESULT_HIGH) begin
            rdDataD = resHigh;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCntQ  <= 5'h00;
            ovfTogQ  <= 1'b0;
            clkEnQ   <= 1'b0;
            inValidQ <= 1'b0;
            inSelQ   <= 4'h0;
            refQ     <= 1'b0;
            gndQ     <= 1'b0;
            irqQ     <= 1'b0;
            rdDataQ  <= 8'h00;
        end else begin
            divCntQ  <= divCntD;
            ovfTogQ  <= ovfTogD;
            clkEnQ   <= clkEnD;
            inValidQ <= inValidD;
            inSelQ   <= inSelD;
            refQ     <= refD;
            gndQ     <= gndD;
            irqQ     <= irqD;
            rdDataQ  <= rdDataD;
        end
    end

    assign sfrRdData               = rdDataQ;
    assign converterOn             = onQ;
    assign coreStart               = coreStartQ;
    assign coreClkEn               = clkEnQ;
    assign analogInputValid        = inValidQ;
    assign analogInputSelect       = inSelQ;
    assign selectInternalReference = refQ;
    assign selectAnalogGround      = gndQ;
    assign converterIrq            = irqQ;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence convEnd;
        endConv;
    endsequence
    window_flag_set_a: assert property (convEnd ##0 winMatch |=> winQ)
        else $error("window flag not set on match");
    window_irq_gate_a: assert property (winQ && wienQ |=> irqQ)
        else $error("window request missing");
    done_flag_set_a: assert property (convEnd |=> doneQ && !startQ)
        else $error("done flag or start bit wrong at completion");
    start_hold_a: assert property (startQ && onQ && !endConv |=> startQ)
        else $error("start bit dropped without completion");
    no_restart_a: assert property ((startQ || doneQ) |=> !coreStartQ)
        else $error("conversion started while busy or done");
    left_just_a: assert property (!rjQ && sfrAddr == acr_pkg::ADDR_RESULT_HIGH && $stable(resultQ)
        && $stable(rjQ) |=> sfrRdData == $past(resultQ[11:4]))
        else $error("left justified high byte wrong");
    right_just_a: assert property (rjQ && sfrAddr == acr_pkg::ADDR_RESULT_HIGH && $stable(resultQ)
        && $stable(rjQ) |=> sfrRdData == {4'h0, $past(resultQ[11:8])})
        else $error("unused high bits not zero");
    done_ignore_a: assert property (doneQ && ignoreQ && !winQ && !smpQ |=> !irqQ)
        else $error("done request not blocked");
    sample_irq_a: assert property (smpQ && sienQ |=> irqQ)
        else $error("sample request missing");
    set_wins_a: assert property (convEnd ##0 (wrCtl && !sfrWrData[acr_pkg::CTL_DONE])
        |=> doneQ)
        else $error("clear beat hardware set");
    saturate_a: assert property (convEnd ##0 sum[13] |=> resultQ == 12'h000)
        else $error("negative result not clamped");

endmodule // acr_adc_control

// [test/acr_core_model.sv]
// analog core stand-in: answers each start with a sample pulse, then a done pulse
// assumes start pulses on clk; the bench sets the next result and the answer delay
`timescale 1ns/1ns
module acr_core_model (
    input  wire logic        clk,
    input  wire logic        coreStart,
    input  wire logic [11:0] nextResult,
    input  wire logic [3:0]  delay,
    output logic             coreSampleDone,
    output logic             coreConvDone,
    output logic      [11:0] coreResult
);
    initial begin
        coreSampleDone = 1'b0;
        coreConvDone   = 1'b0;
        coreResult     = 12'h5a5;
        forever begin
            @(posedge clk);
            if (coreStart === 1'b1) begin
                @(negedge clk) coreSampleDone = 1'b1;
                @(negedge clk) coreSampleDone = 1'b0;
                repeat (delay) @(negedge clk);
                coreConvDone = 1'b1;
                coreResult   = nextResult;
                @(negedge clk) coreConvDone = 1'b0;
                // stale result is inverted so a late capture cannot pass
                coreResult   = ~nextResult;
            end
        end
    end
endmodule // acr_core_model

// [test/adc_control_regs_tb_top.sv]
// self-checking bench for the converter control block
// assumes acr_core_model as analog core; the bench acts as cpu and trigger sources
`timescale 1ns/1ns
module adc_control_regs_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  sfrAddr = 8'h00;
    logic [3:0]  sfrPage = 4'h0;
    logic        sfrWr = 1'b0;
    logic [7:0]  sfrWrData = 8'h00;
    logic [7:0]  sfrRdData;
    logic        t0Ovf = 1'b0;
    logic        u0Ovf = 1'b0;
    logic        t2Ovf = 1'b0;
    logic [1:0]  trigHigh = 2'h0;
    logic        winMode = 1'b0;
    logic [11:0] winHigh = 12'hfff;
    logic [11:0] winLow = 12'h000;
    logic        sDone, cDone, convOn, coreStart, coreClkEn, inValid, selRef, selGnd, irq;
    logic [11:0] cResult;
    logic [3:0]  inSel;
    logic [11:0] nextResult = 12'h000;
    logic [3:0]  delay = 4'h2;
    logic [31:0] seed = 32'h6f1c;
    logic [7:0]  d;
    int          errors = 0, checks_done = 0, starts = 0, clkEns = 0, n;
    // expected results in conversion order
    int          expQ[$];

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (coreStart === 1'b1) starts++;
        if (coreClkEn === 1'b1) clkEns++;
    end

    acr_adc_control dut (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
        .sfrWr(sfrWr), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .timer0Overflow(t0Ovf),
        .uart0BaudOverflow(u0Ovf), .timer2Overflow(t2Ovf), .triggerModeHigh(trigHigh),
        .windowModeSelect(winMode), .windowHighBound(winHigh), .windowLowBound(winLow),
        .coreSampleDone(sDone), .coreConvDone(cDone), .coreResult(cResult),
        .converterOn(convOn), .coreStart(coreStart), .coreClkEn(coreClkEn),
        .analogInputValid(inValid), .analogInputSelect(inSel),
        .selectInternalReference(selRef), .selectAnalogGround(selGnd), .converterIrq(irq));
    acr_core_model core (.clk(clk), .coreStart(coreStart), .nextResult(nextResult),
        .delay(delay), .coreSampleDone(sDone), .coreConvDone(cDone), .coreResult(cResult));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // signed offset then clamp to the code range
    function automatic logic [11:0] fix(input int raw, input logic [4:0] off);
        int v;
        v = raw + (off[4] ? int'(off) - 32 : int'(off));
        if (v < 0) v = 0;
        if (v > 4095) v = 4095;
        return v[11:0];
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chkCnt(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            errors++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] v);
        @(negedge clk);
        sfrAddr = a;
        sfrPage = p;
        sfrWrData = v;
        sfrWr = 1'b1;
        @(negedge clk);
        sfrWr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] p, output logic [7:0] v);
        @(negedge clk);
        sfrAddr = a;
        sfrPage = p;
        @(negedge clk);
        v = sfrRdData;
    endtask
    task automatic ovf(input int w);
        @(negedge clk);
        t0Ovf = (w == 1);
        u0Ovf = (w == 3 || w == 6);
        t2Ovf = (w == 7);
        @(negedge clk);
        {t0Ovf, u0Ovf, t2Ovf} = 3'h0;
    endtask

    task automatic conv(input int i);
        logic [11:0] raw, val, lo, hi;
        logic [7:0]  c0, c1;
        logic [1:0]  tm;
        logic        win;
        int          s0;
        seed = lfsr(seed);
        raw = (i == 0) ? 12'hffe : (i == 1) ? 12'h005 : seed[11:0];
        c1 = {i[1], seed[13:12], (i == 0) ? 5'h0f : (i == 1) ? 5'h10 : seed[20:16]};
        tm = 2'(i / 3);
        c0 = {3'h0, i[0], 2'h0, tm};
        lo = {seed[27:24], 8'h00};
        hi = {seed[31:28], 8'hff};
        expQ.push_back(int'(fix(raw, c1[4:0])));
        @(negedge clk);
        nextResult = raw;
        winLow = lo;
        winHigh = hi;
        winMode = i[2];
        delay = i[0] ? 4'hc : 4'h1;
        wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_1, c1);
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h80);
        s0 = starts;
        wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, c0);
        if (tm == 2'h0) wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h88);
        else if (tm != 2'h2) ovf(tm == 2'h1 ? 1 : 3);
        // a zero written to the start bit mid-conversion must not clear it
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h80);
        n = 0;
        do begin
            rd(acr_pkg::ADDR_CONTROL, 4'h0, d);
            n++;
        end while (d[4] !== 1'b1 && n < 60);
        if (d[4] !== 1'b1) begin
            errors++;
            $display("Error done flag expected 1 seen %b", d[4]);
            end_of_test();
        end
        val = 12'(expQ.pop_front());
        win = i[2] ? (val < lo || val > hi) : (val >= lo && val <= hi);
        chk8("control", {1'b1, win, 6'h10}, d);
        rd(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, d);
        chk8("config0", c0 | 8'h04, d);
        rd(acr_pkg::ADDR_RESULT_HIGH, 4'h0, d);
        chk8("result high", i[0] ? {4'h0, val[11:8]} : val[11:4], d);
        rd(acr_pkg::ADDR_RESULT_LOW, 4'h2, d);
        chk8("result low", i[0] ? val[7:0] : {val[3:0], 4'h0}, d);
        chkCnt("starts", s0 + 1, starts);
        chkBit("irq", !c1[7] | (win & c1[6]) | c1[5], irq);
        // done kept high, so this start request and trigger must be ignored
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h98);
        ovf(tm == 2'h1 ? 1 : 3);
        repeat (20) @(negedge clk);
        chkCnt("refused start", s0 + 1, starts);
        // trigger back to software first, or free-run would restart on the clear
        wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, c0 & 8'hf8);
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h80);
        repeat (3) @(negedge clk);
        chkBit("irq cleared", 1'b0, irq);
        rd(acr_pkg::ADDR_CONTROL, 4'h0, d);
        chk8("control cleared", 8'h80, d);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        $display("Error watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(acr_pkg::ADDR_CONTROL, 4'h0, d);
        chk8("control reset", acr_pkg::RESET_CONTROL, d);
        rd(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, d);
        chk8("config0 reset", acr_pkg::RESET_CONFIG_0, d);
        rd(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_1, d);
        chk8("config1 reset", acr_pkg::RESET_CONFIG_1, d);
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h58);
        wr(acr_pkg::ADDR_RESULT_HIGH, 4'h0, 8'hff);
        rd(acr_pkg::ADDR_CONTROL, 4'h0, d);
        chk8("flag write one", 8'h00, d);
        rd(acr_pkg::ADDR_RESULT_HIGH, 4'h0, d);
        chk8("result read only", 8'h00, d);
        chkCnt("start while off", 0, starts);
        $display("test reset done");
        for (int k = 0; k < 32; k++) begin
            wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, {4'h0, k[4], 3'h0});
            wr(acr_pkg::ADDR_CONTROL, 4'h0, {2'h0, k[3], 2'h0, k[2:0]});
            rd(acr_pkg::ADDR_CONTROL, 4'h0, d);
            chk8("channel bits", {2'h0, k[3], 2'h0, k[2:0]}, d);
            chkBit("input valid", !k[4], inValid);
            if (!k[4]) chk8("input select", {4'h0, k[3:0]}, {4'h0, inSel});
            chkBit("reference", k[4:0] == 5'h10, selRef);
            chkBit("ground", k[4:0] == 5'h11, selGnd);
        end
        $display("test channel decode done");
        for (int k = 0; k < 8; k++) begin
            wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h00);
            wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, {k[2:0], 5'h00});
            wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h80);
            repeat (4) @(negedge clk);
            n = clkEns;
            if (k < 6) begin
                repeat (64) @(negedge clk);
            end else begin
                repeat (8) ovf(k);
                repeat (3) @(negedge clk);
            end
            chkCnt("clock enables", (k < 6) ? (64 >> k) : 4, clkEns - n);
        end
        $display("test clock select done");
        wr(acr_pkg::ADDR_CONTROL, 4'h0, 8'h80);
        repeat (acr_pkg::ENABLE_SETTLE_CYC) @(negedge clk);
        for (int k = 0; k < 12; k++) conv(k);
        $display("test conversions done");
        n = starts;
        wr(acr_pkg::ADDR_CONFIG, acr_pkg::PAGE_CONFIG_0, 8'h01);
        trigHigh = 2'h1;
        ovf(1);
        repeat (10) @(negedge clk);
        chkCnt("upper trigger bits", n, starts);
        trigHigh = 2'h0;
        $display("test upper trigger done");
        end_of_test();
    end
endmodule // adc_control_regs_tb_top
